// File: igd_pkg.sv
package igd_pkg;
  // bus clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  // no-reply timeout after the grant
  localparam int unsigned GRANT_TIMEOUT_US = 12;
  localparam int unsigned GRANT_TIMEOUT_CYC =
    (GRANT_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TMO_W = 10;
  // vector table layout
  localparam logic [15:0] VEC_PC_OFS = 16'h0000;
  localparam logic [15:0] VEC_PS_OFS = 16'h0002;
  // interrupt mask bit of the status word
  localparam int unsigned STATUS_MASK_BIT = 7;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] status;
  } igd_ctx_t;

  typedef enum logic [2:0] {
    IGD_RUN, IGD_WAIT_INSN, IGD_GRANT, IGD_FETCH_PC, IGD_FETCH_PS,
    IGD_HALT
  } igd_state_t;
endpackage

// File: igd_ctx_stack.sv
// one-deep saved context for return from interrupt
module igd_ctx_stack
  import igd_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire igd_ctx_t i_ctx,
  output igd_ctx_t o_ctx
);
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctx <= '0;
    end else if (i_push) begin
      o_ctx <= i_ctx;
    end
  end
endmodule

// File: igd_grant_ctrl.sv
// What this block does
// - request leading edge sets pending latch
// - finish current instruction, then assert grant
// - no reply for 12 us halts processor
// - glitch edges still produce a grant
// - reply reads vector; floating bus is zero
// - load PC from vector, status from plus two
// - return restores interrupted context exactly
module igd_grant_ctrl
  import igd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = GRANT_TIMEOUT_CYC
)(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // backplane
  input wire logic i_interrupt_request_line,
  input wire logic i_bus_reply_line,
  input wire logic i_vector_valid,
  input wire logic [15:0] i_vector,
  output logic o_interrupt_grant,
  // instruction engine
  input wire logic i_insn_done,
  input wire logic i_return_from_interrupt,
  input wire logic i_status_write,
  input wire logic [15:0] i_status_wdata,
  input wire logic [15:0] i_pc,
  // memory read port for vector fetch
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // state
  output logic [15:0] o_new_pc,
  output logic o_pc_load,
  output logic [15:0] o_processor_status_word,
  output logic o_halted,
  output logic o_pending
);
  // elaboration guard: the counter must reach the last timeout count
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << TMO_W)) begin : g_bad_tmo
    $error("igd_grant_ctrl: TIMEOUT_CYC out of range");
  end

  igd_state_t state;
  logic req_q;
  logic [15:0] vec;
  logic [TMO_W-1:0] tmo;
  igd_ctx_t saved_ctx;
  igd_ctx_t cur_ctx;
  wire req_rise = i_interrupt_request_line & ~req_q;
  wire masked = o_processor_status_word[STATUS_MASK_BIT];
  wire take_int = state == IGD_RUN && o_pending && !masked;
  wire enter_fetch = state == IGD_GRANT && i_bus_reply_line;

  assign cur_ctx = '{pc: i_pc, status: o_processor_status_word};

  igd_ctx_stack u_stack (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_push(enter_fetch),
    .i_ctx(cur_ctx),
    .o_ctx(saved_ctx)
  );

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= i_interrupt_request_line;
    end
  end

  // any rising edge, real or noise, sets pending; set beats clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pending <= 1'b0;
    end else if (req_rise) begin
      o_pending <= 1'b1;
    end else if (enter_fetch) begin
      o_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= IGD_RUN;
    end else begin
      case (state)
        IGD_RUN: begin
          if (take_int) begin
            state <= IGD_WAIT_INSN;
          end
        end
        IGD_WAIT_INSN: begin
          if (i_insn_done) begin
            state <= IGD_GRANT;
          end
        end
        IGD_GRANT: begin
          if (i_bus_reply_line) begin
            state <= IGD_FETCH_PC;
          end else if (tmo == TMO_W'(TIMEOUT_CYC - 1)) begin
            state <= IGD_HALT;
          end
        end
        IGD_FETCH_PC: begin
          if (i_mem_ack) begin
            state <= IGD_FETCH_PS;
          end
        end
        IGD_FETCH_PS: begin
          if (i_mem_ack) begin
            state <= IGD_RUN;
          end
        end
        default: begin
          state <= IGD_HALT;
        end
      endcase
    end
  end

  // timeout counter runs only while the grant is out
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tmo <= '0;
    end else if (state == IGD_GRANT && !i_bus_reply_line) begin
      tmo <= tmo + TMO_W'(1);
    end else begin
      tmo <= '0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_interrupt_grant <= 1'b0;
    end else begin
      o_interrupt_grant <= (state == IGD_WAIT_INSN && i_insn_done) ||
        (state == IGD_GRANT && !i_bus_reply_line &&
         tmo != TMO_W'(TIMEOUT_CYC - 1));
    end
  end

  // undriven data bus reads as vector zero
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      vec <= '0;
    end else if (enter_fetch) begin
      vec <= i_vector_valid ? i_vector : 16'h0000;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_rd <= 1'b0;
      o_mem_addr <= '0;
    end else begin
      o_mem_rd <= (state == IGD_FETCH_PC && !i_mem_ack) ||
        (state == IGD_FETCH_PS && !i_mem_ack) || enter_fetch;
      if (enter_fetch) begin
        o_mem_addr <= (i_vector_valid ? i_vector : 16'h0000)
          + VEC_PC_OFS;
      end else if (state == IGD_FETCH_PC && i_mem_ack) begin
        o_mem_addr <= vec + VEC_PS_OFS;
        o_mem_rd <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_new_pc <= PC_RESET;
      o_pc_load <= 1'b0;
    end else begin
      o_pc_load <= 1'b0;
      if (state == IGD_FETCH_PC && i_mem_ack) begin
        o_new_pc <= i_mem_rdata;
      end
      if (state == IGD_FETCH_PS && i_mem_ack) begin
        o_pc_load <= 1'b1;
      end else if (state == IGD_RUN && i_return_from_interrupt) begin
        o_new_pc <= saved_ctx.pc;
        o_pc_load <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_processor_status_word <= STATUS_RESET;
    end else if (state == IGD_FETCH_PS && i_mem_ack) begin
      o_processor_status_word <= i_mem_rdata;
    end else if (state == IGD_RUN && i_return_from_interrupt) begin
      o_processor_status_word <= saved_ctx.status;
    end else if (i_status_write) begin
      o_processor_status_word <= i_status_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_halted <= 1'b0;
    end else if (state == IGD_GRANT && !i_bus_reply_line &&
                 tmo == TMO_W'(TIMEOUT_CYC - 1)) begin
      o_halted <= 1'b1;
    end
  end

  chk_edge_sets_pending: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    req_rise |=> o_pending)
    else $error("request edge did not set pending");

  chk_grant_after_insn: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_interrupt_grant) |-> $past(i_insn_done))
    else $error("grant before instruction completed");

  chk_timeout_halts: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_interrupt_grant) ##1 (!i_bus_reply_line)[*2]
    |-> ##[0:1000] o_halted || i_bus_reply_line)
    else $error("no halt after unanswered grant");

  chk_reply_cancels: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (state == IGD_GRANT && i_bus_reply_line) |=> !o_interrupt_grant
      && !o_halted && tmo == '0)
    else $error("reply did not cancel timeout");

  chk_zero_vector: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (enter_fetch && !i_vector_valid) |=> o_mem_addr == VEC_PC_OFS)
    else $error("floating vector not read as zero");

  chk_ps_addr: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (state == IGD_FETCH_PC && i_mem_ack) |=>
      o_mem_addr == vec + VEC_PS_OFS && o_new_pc == $past(i_mem_rdata))
    else $error("status fetch address wrong");

  chk_return_restore: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (state == IGD_RUN && i_return_from_interrupt) |=>
      o_pc_load && o_new_pc == $past(saved_ctx.pc) &&
      o_processor_status_word == $past(saved_ctx.status))
    else $error("return did not restore context");

  chk_halt_drops_grant: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    o_halted |-> !o_interrupt_grant)
    else $error("grant still out while halted");

  chk_glitch_grant: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (state == IGD_WAIT_INSN && i_insn_done) |=> o_interrupt_grant)
    else $error("pending did not produce grant");
endmodule

// File: igd_board_model.sv
module igd_board_model
  import igd_pkg::*;
#(
  parameter logic [15:0] VEC = 16'h0040
)(
  // board controls
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic i_enable,
  input wire logic i_noise,
  input wire logic i_strap,
  // backplane
  input wire logic i_interrupt_grant,
  output logic o_interrupt_request_line,
  output logic o_grant_chain_out,
  output logic o_bus_reply_line,
  output logic o_vector_valid,
  output logic [15:0] o_vector,
  // memory
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  output logic o_mem_ack,
  output logic [15:0] o_mem_rdata
);
  logic claim;
  assign o_interrupt_request_line = i_req | i_noise;
  assign claim = i_interrupt_grant & i_req & i_enable;
  assign o_grant_chain_out = i_interrupt_grant & ~claim;
  assign o_bus_reply_line = claim | (i_strap & o_grant_chain_out);
  assign o_vector_valid = claim;
  // a released bus shows the inverse, never the last vector
  assign o_vector = claim ? VEC : ~VEC;
  // location zero holds only the planted words
  always_comb begin
    case (i_mem_addr)
      16'h0000: o_mem_rdata = 16'h0002;
      16'h0002: o_mem_rdata = 16'h0002;
      VEC: o_mem_rdata = 16'h1234;
      VEC + 16'h0002: o_mem_rdata = 16'h0005;
      default: o_mem_rdata = ~i_mem_addr;
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_ack <= 1'b0;
    end else begin
      o_mem_ack <= i_mem_rd & ~o_mem_ack;
    end
  end
endmodule

// File: interrupt_grant_daisy_chain_tb.sv
module interrupt_grant_daisy_chain_tb
  import igd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 8;
  logic clk, rst, req, en, noise, strap, insn, ret_int, stat_wr;
  logic [15:0] stat_wd, pc;
  logic irq, reply, vvalid, grant, mem_rd, mem_ack, pc_load, halted, pending;
  logic [15:0] vec, mem_addr, mem_rdata, new_pc, status;
  int num_errors, comparisons;

  igd_grant_ctrl #(.TIMEOUT_CYC(TMO)) DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_interrupt_request_line(irq),
    .i_bus_reply_line(reply), .i_vector_valid(vvalid), .i_vector(vec),
    .o_interrupt_grant(grant), .i_insn_done(insn),
    .i_return_from_interrupt(ret_int), .i_status_write(stat_wr),
    .i_status_wdata(stat_wd), .i_pc(pc), .o_mem_rd(mem_rd),
    .o_mem_addr(mem_addr), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
    .o_new_pc(new_pc), .o_pc_load(pc_load),
    .o_processor_status_word(status), .o_halted(halted),
    .o_pending(pending));

  igd_board_model board (
    .i_sys_clk(clk), .i_rst(rst), .i_req(req), .i_enable(en),
    .i_noise(noise), .i_strap(strap), .i_interrupt_grant(grant),
    .o_interrupt_request_line(irq), .o_grant_chain_out(),
    .o_bus_reply_line(reply), .o_vector_valid(vvalid), .o_vector(vec),
    .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .o_mem_ack(mem_ack),
    .o_mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_grant();
    for (int n = 0; n < 20 && grant !== 1'b1; n++) tick(1);
  endtask

  task automatic wait_load();
    for (int n = 0; n < 40 && pc_load !== 1'b1; n++) tick(1);
  endtask

  task automatic pulse_insn();
    insn = 1'b1;
    tick(1);
    insn = 1'b0;
  endtask

  task automatic write_status(input logic [15:0] v);
    stat_wr = 1'b1;
    stat_wd = v;
    tick(1);
    stat_wr = 1'b0;
  endtask

  task automatic t_masked_then_served();
    write_status(16'h0080);
    tick(1);
    chk(status, 16'h0080);
    req = 1'b1;
    en = 1'b1;
    tick(4);
    pulse_insn();
    tick(3);
    chk({15'h0, pending}, 16'h0001);
    chk({15'h0, grant}, 16'h0000);
    write_status(16'h0000);
    tick(4);
    chk({15'h0, grant}, 16'h0000);
    pulse_insn();
    wait_grant();
    chk({15'h0, grant}, 16'h0001);
    wait_load();
    chk({15'h0, pc_load}, 16'h0001);
    chk(mem_addr, 16'h0042);
    chk({15'h0, mem_rd}, 16'h0000);
    chk(new_pc, 16'h1234);
    chk(status, 16'h0005);
    req = 1'b0;
    tick(TMO + 4);
    chk({15'h0, halted}, 16'h0000);
  endtask

  task automatic t_glitch_strap_return();
    pc = 16'h0300;
    strap = 1'b1;
    noise = 1'b1;
    tick(1);
    noise = 1'b0;
    tick(2);
    pulse_insn();
    wait_grant();
    chk({15'h0, grant}, 16'h0001);
    wait_load();
    chk({15'h0, pc_load}, 16'h0001);
    chk(mem_addr, 16'h0002);
    chk(new_pc, 16'h0002);
    chk(status, 16'h0002);
    pc = 16'h0002;
    tick(1);
    ret_int = 1'b1;
    tick(1);
    ret_int = 1'b0;
    wait_load();
    chk({15'h0, pc_load}, 16'h0001);
    chk(new_pc, 16'h0300);
    chk(status, 16'h0005);
    strap = 1'b0;
  endtask

  task automatic t_no_reply();
    en = 1'b0;
    req = 1'b1;
    tick(2);
    pulse_insn();
    wait_grant();
    chk({15'h0, grant}, 16'h0001);
    tick(TMO - 3);
    chk({15'h0, halted}, 16'h0000);
    tick(6);
    chk({15'h0, halted}, 16'h0001);
    chk({15'h0, grant}, 16'h0000);
  endtask

  task automatic t_reset_clears();
    req = 1'b0;
    tick(1);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    chk({15'h0, halted}, 16'h0000);
    chk({15'h0, pending}, 16'h0000);
    chk(status, 16'h0000);
    en = 1'b1;
    req = 1'b1;
    tick(2);
    pulse_insn();
    wait_grant();
    chk({15'h0, grant}, 16'h0001);
    wait_load();
    chk({15'h0, pc_load}, 16'h0001);
    chk(new_pc, 16'h1234);
  endtask

  initial begin
    {req, en, noise, strap, insn, ret_int, stat_wr} = '0;
    stat_wd = 16'h0000;
    pc = 16'h0100;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(1);
    t_masked_then_served();
    t_glitch_strap_return();
    t_no_reply();
    t_reset_clears();
    final_report();
  end

  initial begin
    #(3000 * 20);
    num_errors++;
    final_report();
  end
endmodule
